// >>> logic/scp_serial_port.sv
/*
 * Serial control port of the device: register file behind a host-driven
 * serial link, daisy-chain output, event flags and an open-drain interrupt.
 * Frames cross from the bit clock with a toggle and a three-flop filter;
 * the frame word itself is held still by the link and needs no crossing.
 * Read answers leave in the data phase of the frame that follows.
 * Assumes a 25 MHz system clock, a host bit clock that stops outside
 * frames, and a reset pin pulled low on the board when undriven.
 * Event inputs come from logic on the system clock and are not filtered.
 * Board pull-ups sit at the pads, outside this logic.
 */
`timescale 1ns/1ns
`default_nettype none

module scp_serial_port #(
    parameter int N_CTRL   = 8,
    parameter int N_EVENTS = 8
) (
    // system clock and reset
    input  wire logic                i_clk_sys,
    input  wire logic                i_rst_b,
    // serial link from the host
    input  wire logic                i_sclk,
    input  wire logic                i_cs_b,
    input  wire logic                i_sdi,
    // serial data out, three-state
    output logic                     o_sdo_o,
    output logic                     o_sdo_oe,
    // daisy chain
    output logic                     o_daisy_chain_out,
    // interrupt, open drain
    output logic                     o_int_o,
    output logic                     o_int_oe,
    // device events and control outputs
    input  wire logic [N_EVENTS-1:0] i_event,
    output logic [N_CTRL*8-1:0]      o_ctrl
);

    localparam int AW = scp_pkg::ADDR_W;
    localparam int DW = scp_pkg::DATA_W;
    localparam logic [AW-1:0] CTRL_END = scp_pkg::ADDR_CTRL0 + AW'(N_CTRL);

    // link side
    scp_pkg::scp_cmd_t link_cmd;
    logic              link_tgl;
    logic              link_sdo;
    logic [DW-1:0]     rd_hold_q;

    // system side
    logic              tgl_sync;
    logic              tgl_seen_q;
    logic              cmd_stb;
    scp_pkg::scp_cmd_t cmd_q;
    logic              cmd_vld_q;
    logic [DW-1:0]     ctrl_q [N_CTRL];
    logic [DW-1:0]     mask_q;
    logic [DW-1:0]     intcfg_q;
    logic [DW-1:0]     status_q;
    logic [DW-1:0]     status_d;
    logic [DW-1:0]     wcnt_q;
    logic [DW-1:0]     ev_q;
    logic [DW-1:0]     ev_rise;
    logic [DW-1:0]     rd_val;
    logic              int_q;
    logic              wr_en;

    // decoded strobes and next values
    logic              rd_en;
    logic              wr_ctrl;
    logic              wr_mask;
    logic              wr_intcfg;
    logic              wr_status;
    logic [DW-1:0]     status_clr;
    logic [DW-1:0]     ev_now;
    logic [DW-1:0]     wcnt_d;
    logic [DW-1:0]     rd_misc;
    logic              int_req;

    // address decode helpers
    function automatic logic is_ctrl(input logic [AW-1:0] a);
        is_ctrl = (a >= scp_pkg::ADDR_CTRL0) &&
                  (a < CTRL_END);
    endfunction

    function automatic int ctrl_idx(input logic [AW-1:0] a);
        ctrl_idx = int'(a - scp_pkg::ADDR_CTRL0);
    endfunction

    function automatic logic addr_hit(
        input logic [AW-1:0] a,
        input logic [AW-1:0] target
    );
        addr_hit = (a == target);
    endfunction

    function automatic logic [DW-1:0] widen_events(
        input logic [N_EVENTS-1:0] e
    );
        logic [DW-1:0] r;
        r = '0;
        for (int i = 0; i < N_EVENTS && i < DW; i++) begin
            r[i] = e[i];
        end
        widen_events = r;
    endfunction

    // link-domain shifter on the host's bit clock
    scp_link u_link (
        .i_sclk            (i_sclk),
        .i_cs_b            (i_cs_b),
        .i_sdi             (i_sdi),
        .i_rst_b           (i_rst_b),
        .i_rd_data         (rd_hold_q),
        .o_sdo             (link_sdo),
        .o_daisy_chain_out (o_daisy_chain_out),
        .o_cmd             (link_cmd),
        .o_cmd_tgl         (link_tgl)
    );

    // data out floats while deselected
    assign o_sdo_o  = link_sdo;
    assign o_sdo_oe = ~i_cs_b;

    // frame toggle into the system domain
    scp_sync u_sync_tgl (
        .i_clk_sys (i_clk_sys),
        .i_rst_b   (i_rst_b),
        .i_d       (link_tgl),
        .o_q       (tgl_sync)
    );

    // one strobe per frame, never two for one toggle
    assign cmd_stb = (tgl_sync != tgl_seen_q);

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            tgl_seen_q <= 1'b0;
        end else begin
            tgl_seen_q <= tgl_sync;
        end
    end

    // frame word held still by the link until the next frame ends
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            cmd_q <= '0;
        end else if (cmd_stb) begin
            cmd_q <= link_cmd;
        end
    end

    // one-cycle strobe, in the same cycle as the captured word
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            cmd_vld_q <= 1'b0;
        end else begin
            cmd_vld_q <= cmd_stb;
        end
    end

    // command decode, shared by every register below except ev_q and int_q
    assign wr_en     = cmd_vld_q && !cmd_q.rd;
    assign rd_en     = cmd_vld_q && cmd_q.rd;
    assign wr_ctrl   = wr_en && is_ctrl(cmd_q.addr);
    assign wr_mask   = wr_en && addr_hit(cmd_q.addr, scp_pkg::ADDR_MASK);
    assign wr_intcfg = wr_en && addr_hit(cmd_q.addr, scp_pkg::ADDR_INTCFG);
    assign wr_status = wr_en && addr_hit(cmd_q.addr, scp_pkg::ADDR_STATUS);

    // control registers; undriven pin reads low and holds them reset
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            for (int i = 0; i < N_CTRL; i++) begin
                ctrl_q[i] <= scp_pkg::RST_CTRL;
            end
        end else if (wr_ctrl) begin
            ctrl_q[ctrl_idx(cmd_q.addr)] <= cmd_q.data;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            mask_q <= scp_pkg::RST_MASK;
        end else if (wr_mask) begin
            mask_q <= cmd_q.data;
        end
    end

    // global enable lives in one bit; the rest is kept but unused
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            intcfg_q <= scp_pkg::RST_INTCFG;
        end else if (wr_intcfg) begin
            intcfg_q <= cmd_q.data;
        end
    end

    assign wcnt_d = wcnt_q + 8'h01;

    // count of write frames to any address, mapped or not, wraps
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            wcnt_q <= scp_pkg::RST_WCNT;
        end else if (wr_en) begin
            wcnt_q <= wcnt_d;
        end
    end

    // events arrive from same-clock logic; flag on rising level
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            ev_q <= '0;
        end else begin
            ev_q <= ev_now;
        end
    end

    assign ev_now  = widen_events(i_event);
    assign ev_rise = ev_now & ~ev_q;

    // clear mask taken from a status write
    assign status_clr = wr_status ? cmd_q.data : '0;

    // write one to clear; a new event in the same cycle wins
    always_comb begin
        status_d = status_q & ~status_clr;
        status_d = status_d | ev_rise;
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            status_q <= scp_pkg::RST_STATUS;
        end else begin
            status_q <= status_d;
        end
    end

    // request leaves registered; pin only ever pulls low
    assign int_req = intcfg_q[scp_pkg::INTCFG_EN_BIT] &&
                     |(status_q & mask_q);

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            int_q <= 1'b0;
        end else begin
            int_q <= int_req;
        end
    end

    assign o_int_o  = 1'b0;
    assign o_int_oe = int_q;

    // fixed registers; unmapped words read zero
    always_comb begin
        rd_misc = '0;
        case (cmd_q.addr)
            scp_pkg::ADDR_ID:     rd_misc = scp_pkg::ID_VALUE;
            scp_pkg::ADDR_STATUS: rd_misc = status_q;
            scp_pkg::ADDR_MASK:   rd_misc = mask_q;
            scp_pkg::ADDR_INTCFG: rd_misc = intcfg_q;
            scp_pkg::ADDR_WCNT:   rd_misc = wcnt_q;
            scp_pkg::ADDR_RAW:    rd_misc = ev_q;
            default:              rd_misc = '0;
        endcase
    end

    // control window overrides the fixed map
    always_comb begin
        rd_val = rd_misc;
        if (is_ctrl(cmd_q.addr)) begin
            rd_val = ctrl_q[ctrl_idx(cmd_q.addr)];
        end
    end

    // read answer goes out in the next frame; the link samples it only
    // mid-frame, long after this settles, so no word crossing is needed
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            rd_hold_q <= '0;
        end else if (rd_en) begin
            rd_hold_q <= rd_val;
        end
    end

    // control registers to the device
    always_comb begin
        for (int i = 0; i < N_CTRL; i++) begin
            o_ctrl[i*8 +: 8] = ctrl_q[i];
        end
    end

endmodule

`default_nettype wire

// >>> logic/scp_pkg.sv
/*
 * Shared constants and types of the serial control port: frame layout,
 * register map, reset values and the command word carried across clocks.
 * Assumes nothing of its surroundings; every user names scp_pkg::x in full.
 */
package scp_pkg;

    // frame layout: direction bit, address, data, first bit on the wire first
    localparam int FRAME_BITS = 16;
    localparam int ADDR_W     = 7;
    localparam int DATA_W     = 8;
    localparam int CNT_W      = 4;
    localparam logic [CNT_W-1:0] DATA_START = 4'h8;
    localparam logic [CNT_W-1:0] LAST_BIT   = 4'hf;

    // register map, word addresses carried in the frame
    localparam logic [ADDR_W-1:0] ADDR_ID     = 7'h00;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 7'h01;
    localparam logic [ADDR_W-1:0] ADDR_MASK   = 7'h02;
    localparam logic [ADDR_W-1:0] ADDR_INTCFG = 7'h03;
    localparam logic [ADDR_W-1:0] ADDR_WCNT   = 7'h04;
    localparam logic [ADDR_W-1:0] ADDR_RAW    = 7'h05;
    localparam logic [ADDR_W-1:0] ADDR_CTRL0  = 7'h08;

    // field positions
    localparam int INTCFG_EN_BIT = 0;

    // reset values
    localparam logic [DATA_W-1:0] RST_MASK   = 8'h00;
    localparam logic [DATA_W-1:0] RST_INTCFG = 8'h00;
    localparam logic [DATA_W-1:0] RST_CTRL   = 8'h00;
    localparam logic [DATA_W-1:0] RST_STATUS = 8'h00;
    localparam logic [DATA_W-1:0] RST_WCNT   = 8'h00;
    // arbitrary identity value, names no real part
    localparam logic [DATA_W-1:0] ID_VALUE   = 8'h5a;

    // one received frame
    typedef struct packed {
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } scp_cmd_t;

endpackage

// >>> logic/scp_sync.sv
/*
 * Three-stage synchroniser for a level entering the system clock domain.
 * The output moves only once the second and third stages agree.
 * Assumes a synchronous active-low reset on the destination clock.
 */
`timescale 1ns/1ns
`default_nettype none

module scp_sync (
    // clock and reset
    input  wire logic i_clk_sys,
    input  wire logic i_rst_b,
    // level in and out
    input  wire logic i_d,
    output var  logic o_q
);

    logic s1_q;
    logic s2_q;
    logic s3_q;

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else begin
            s1_q <= i_d;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // agreement filter, never looks at the first stage
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            o_q <= 1'b0;
        end else if (s2_q == s3_q) begin
            o_q <= s3_q;
        end
    end

endmodule

`default_nettype wire

// >>> logic/scp_link.sv
/*
 * Link-side shifter of the serial control port, clocked by the host's bit
 * clock. Captures input bits on the rising edge, launches output bits on
 * the falling edge, and hands each whole frame over with a toggle.
 * Assumes the bit clock only runs while chip select is low.
 */
`timescale 1ns/1ns
`default_nettype none

module scp_link (
    // link clock and pins
    input  wire logic              i_sclk,
    input  wire logic              i_cs_b,
    input  wire logic              i_sdi,
    input  wire logic              i_rst_b,
    // read data, stable during frames
    input  wire logic [7:0]        i_rd_data,
    // pin outputs
    output var  logic              o_sdo,
    output var  logic              o_daisy_chain_out,
    // frame handover
    output var  scp_pkg::scp_cmd_t o_cmd,
    output var  logic              o_cmd_tgl
);

    logic [scp_pkg::CNT_W-1:0]      cnt_q;
    logic [scp_pkg::FRAME_BITS-2:0] sh_q;
    logic [scp_pkg::DATA_W-1:0]     out_q;

    // chip select high holds the shifter cleared
    always_ff @(posedge i_sclk or posedge i_cs_b) begin
        if (i_cs_b) begin
            cnt_q <= '0;
            sh_q  <= '0;
        end else begin
            cnt_q <= cnt_q + 4'h1;
            sh_q  <= {sh_q[scp_pkg::FRAME_BITS-3:0], i_sdi};
        end
    end

    // a frame completes on its sixteenth rising edge; toggle survives frames
    always_ff @(posedge i_sclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_cmd     <= '0;
            o_cmd_tgl <= 1'b0;
        end else if (!i_cs_b && cnt_q == scp_pkg::LAST_BIT) begin
            o_cmd     <= {sh_q, i_sdi};
            o_cmd_tgl <= ~o_cmd_tgl;
        end
    end

    // output side on the falling edge; idle daisy chain pulled high
    always_ff @(negedge i_sclk or posedge i_cs_b) begin
        if (i_cs_b) begin
            out_q             <= '0;
            o_daisy_chain_out <= 1'b1;
        end else begin
            o_daisy_chain_out <= sh_q[0];
            if (cnt_q == scp_pkg::DATA_START) begin
                out_q <= i_rd_data;
            end else begin
                out_q <= {out_q[scp_pkg::DATA_W-2:0], 1'b0};
            end
        end
    end

    assign o_sdo = out_q[scp_pkg::DATA_W-1];

endmodule

`default_nettype wire

// >>> verif/scp_monitor.sv
/*
 * Checker of the serial control port pins, bound to the top module.
 * Assumes the host bit clock idles low outside frames.
 */
`timescale 1ns/1ns
`default_nettype none
module scp_monitor #(
    parameter int N_CTRL   = 8,
    parameter int N_EVENTS = 8
) (
    // system side
    input wire logic                i_clk_sys,
    input wire logic                i_rst_b,
    input wire logic [N_EVENTS-1:0] i_event,
    input wire logic [N_CTRL*8-1:0] o_ctrl,
    input wire logic                o_int_o,
    input wire logic                o_int_oe,
    // link side
    input wire logic                i_sclk,
    input wire logic                i_cs_b,
    input wire logic                i_sdi,
    input wire logic                o_sdo_o,
    input wire logic                o_sdo_oe,
    input wire logic                o_daisy_chain_out
);
    logic [3:0] n_q;
    // rising edges in the frame; cs high clears at once
    always_ff @(posedge i_sclk or posedge i_cs_b) begin
        if (i_cs_b) begin
            n_q <= 4'h0;
        end else begin
            n_q <= n_q + 4'h1;
        end
    end
    chk_sdo_float: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        i_cs_b |-> !o_sdo_oe) else $error("data out driven while deselected");
    chk_sdo_drive: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        !i_cs_b |-> o_sdo_oe) else $error("data out floats while selected");
    chk_daisy_idle: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        i_cs_b && $past(i_cs_b) |-> o_daisy_chain_out)
        else $error("daisy output low while idle");
    chk_int_open_drain: assert property (@(posedge i_clk_sys)
        disable iff (!i_rst_b) !o_int_o) else $error("interrupt driven high");
    chk_ctrl_quiet: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        i_cs_b [*8] |=> $stable(o_ctrl)) else $error("control changed while idle");
    chk_reset_ctrl: assert property (@(posedge i_clk_sys)
        !i_rst_b ##1 !i_rst_b |-> o_ctrl == '0 && !o_int_oe)
        else $error("outputs not cleared in reset");
    chk_sdo_lead: assert property (@(posedge i_sclk)
        disable iff (!i_rst_b || i_cs_b) n_q != 4'h0 && n_q < 4'h8 |-> !o_sdo_o)
        else $error("data out not low in command phase");
    chk_daisy_fwd: assert property (@(posedge i_sclk)
        disable iff (!i_rst_b || i_cs_b)
        n_q != 4'h0 |-> o_daisy_chain_out == $past(i_sdi))
        else $error("daisy output lost a bit");
    cover property (@(posedge i_sclk) n_q == 4'hf);
    cover property (@(posedge i_clk_sys) $rose(o_int_oe));
    cover property (@(posedge i_clk_sys) !i_rst_b);
endmodule
`default_nettype wire

// >>> verif/scp_host_model.sv
/*
 * Host model of the serial control port: drives select, bit clock and
 * data in at 64 ns per bit. Assumes data out is seen as resolved wire.
 */
`timescale 1ns/1ns
`default_nettype none
module scp_host_model (
    // link pins
    output var logic o_sclk,
    output var logic o_cs_b,
    output var logic o_sdi,
    input wire logic i_sdo,
    input wire logic i_daisy
);
    initial begin
        o_sclk = 1'b0;
        o_cs_b = 1'b1;
        o_sdi = 1'b0;
    end
    // nb bits msb first; fewer than 16 leaves a broken frame
    task automatic frame(input logic [15:0] w, input int nb,
                         output logic [15:0] echo, output logic [7:0] rd);
        echo = 16'h0;
        rd = 8'h0;
        o_cs_b = 1'b0;
        for (int k = 0; k < nb; k++) begin
            o_sdi = w[15-k];
            #32;
            if (k > 0) echo[16-k] = i_daisy;
            if (k > 7) rd[15-k] = i_sdo;
            o_sclk = 1'b1;
            #32;
            o_sclk = 1'b0;
        end
        #8;
        echo[0] = i_daisy;
        #24;
        o_cs_b = 1'b1;
        // released line must not show the last bit
        o_sdi = ~o_sdi;
    endtask
    // clock and data wiggle with select high
    task automatic noise(input int n);
        for (int k = 0; k < n; k++) begin
            o_sdi = ~o_sdi;
            #32 o_sclk = 1'b1;
            #32 o_sclk = 1'b0;
        end
    endtask
endmodule
`default_nettype wire

// >>> verif/tb.sv
/*
 * Top bench of the serial control port: reset pin, events, host model.
 * Assumes inputs change at the falling system clock edge.
 */
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic        clk, rst_drv, rst_en;
    logic [7:0]  ev;
    logic        sclk, cs_b, sdi, sdo_o, sdo_oe, daisy, int_o, int_oe;
    logic [63:0] ctrl;
    int          failures, n_compared;
    wire logic   rst_b = rst_en ? rst_drv : 1'b0;
    wire logic   sdo = sdo_oe ? sdo_o : 1'bz;
    wire logic   int_n = int_oe ? int_o : 1'b1;
    scp_serial_port #(.N_CTRL(8), .N_EVENTS(8)) scp_serial_port_i (
        .i_clk_sys(clk), .i_rst_b(rst_b), .i_sclk(sclk), .i_cs_b(cs_b),
        .i_sdi(sdi), .o_sdo_o(sdo_o), .o_sdo_oe(sdo_oe),
        .o_daisy_chain_out(daisy), .o_int_o(int_o), .o_int_oe(int_oe),
        .i_event(ev), .o_ctrl(ctrl));
    scp_host_model scp_host_model_i (.o_sclk(sclk), .o_cs_b(cs_b),
        .o_sdi(sdi), .i_sdo(sdo), .i_daisy(daisy));
    task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic xfer(input logic [15:0] w, output logic [7:0] rd);
        logic [15:0] e;
        scp_host_model_i.frame(w, 16, e, rd);
        cmp(64'(e), 64'(w));
        repeat (8) @(negedge clk);
    endtask
    task automatic t_reset;
        cmp(ctrl, 64'h0);
        cmp(64'({sdo_oe, daisy, int_n}), 64'h3);
        $display("done reset");
    endtask
    task automatic t_write;
        logic [7:0] r;
        xfer(16'h08a5, r);
        xfer(16'h0f3c, r);
        cmp(ctrl, {8'h3c, 48'h0, 8'ha5});
        $display("done write");
    endtask
    task automatic t_read;
        logic [7:0] r;
        xfer(16'h8800, r);
        xfer(16'h8000, r);
        cmp(64'(r), 64'ha5);
        xfer(16'hff00, r);
        cmp(64'(r), 64'(scp_pkg::ID_VALUE));
        xfer(16'h0000, r);
        cmp(64'(r), 64'h0);
        xfer(16'h8400, r);
        xfer(16'h8200, r);
        cmp(64'(r), 64'h03);
        $display("done read");
    endtask
    task automatic t_deselect;
        logic [15:0] e;
        logic [7:0]  r;
        scp_host_model_i.noise(20);
        cmp(64'({sdo_oe, daisy}), 64'h1);
        scp_host_model_i.frame(16'h09ff, 12, e, r);
        repeat (10) @(negedge clk);
        cmp(ctrl, {8'h3c, 48'h0, 8'ha5});
        $display("done deselect");
    endtask
    task automatic t_irq;
        logic [7:0] r;
        xfer(16'h0201, r);
        xfer(16'h0301, r);
        ev = 8'h01;
        @(negedge clk);
        ev = 8'h00;
        repeat (4) @(negedge clk);
        cmp(64'(int_n), 64'h0);
        xfer(16'h8100, r);
        xfer(16'h8500, r);
        cmp(64'(r), 64'h01);
        xfer(16'h0200, r);
        cmp(64'(r), 64'h00);
        cmp(64'(int_n), 64'h1);
        xfer(16'h0201, r);
        cmp(64'(int_n), 64'h0);
        xfer(16'h0101, r);
        cmp(64'(int_n), 64'h1);
        $display("done irq");
    endtask
    task automatic t_rst_pin;
        logic [7:0] r;
        ev = 8'h01;
        @(negedge clk);
        ev = 8'h00;
        repeat (3) @(negedge clk);
        cmp(64'(int_n), 64'h0);
        rst_en = 1'b0;
        repeat (6) @(negedge clk);
        cmp(ctrl, 64'h0);
        cmp(64'(int_n), 64'h1);
        rst_en = 1'b1;
        repeat (2) @(negedge clk);
        xfer(16'h8300, r);
        xfer(16'h8000, r);
        cmp(64'(r), 64'h00);
        $display("done reset pin");
    endtask
    task automatic report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        #200000;
        failures++;
        report_and_stop();
    end
    initial begin
        failures = 0;
        n_compared = 0;
        rst_en = 1'b1;
        rst_drv = 1'b0;
        ev = 8'h00;
        repeat (16) @(negedge clk);
        rst_drv = 1'b1;
        @(negedge clk);
        t_reset();
        t_write();
        t_read();
        t_deselect();
        t_irq();
        t_rst_pin();
        report_and_stop();
    end
endmodule
bind scp_serial_port scp_monitor #(.N_CTRL(N_CTRL), .N_EVENTS(N_EVENTS))
    scp_monitor_i (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b),
    .i_event(i_event), .o_ctrl(o_ctrl), .o_int_o(o_int_o),
    .o_int_oe(o_int_oe), .i_sclk(i_sclk), .i_cs_b(i_cs_b), .i_sdi(i_sdi),
    .o_sdo_o(o_sdo_o), .o_sdo_oe(o_sdo_oe),
    .o_daisy_chain_out(o_daisy_chain_out));
`default_nettype wire
